// ---- inc/vic_cfg.svh ----
// Constants for the vectored interrupt controller.
`ifndef VIC_CFG_SVH
`define VIC_CFG_SVH
`define VIC_LEVELS        6
`define VIC_MASTER_BIT    7
`define VIC_PROTECT_BIT   6
`define VIC_EDGE_LO_BIT   6
`define VIC_EDGE_HI_BIT   7
`define VIC_REQ_RESET     8'h00
`define VIC_ACK_CYCLES    5'h18
// Sequencer counter values at which each acknowledge state is left.
`define VIC_ACK_LAST      5'h16
`define VIC_STEP_PCL      5'h02
`define VIC_STEP_PCH      5'h04
`define VIC_STEP_FLG      5'h08
`define VIC_STEP_VHI      5'h0E
`define VIC_STEP_VLO      5'h12
`define VIC_PRI_GRP_C     1
`define VIC_PRI_GRP_B     2
`define VIC_PRI_GRP_A     5
`define VIC_PRI_ORD_0     0
`define VIC_PRI_ORD_1     3
`define VIC_PRI_ORD_2     4
`endif

// ---- inc/vic_pkg.sv ----
// Types shared by the interrupt controller modules.
`default_nettype none
package vic_pkg;
  typedef enum logic [2:0] {
    VIC_IDLE,
    VIC_PUSH_PCL,
    VIC_PUSH_PCH,
    VIC_PUSH_FLG,
    VIC_FETCH_VHI,
    VIC_FETCH_VLO,
    VIC_BRANCH
  } vic_ack_state_t;
  typedef logic [2:0] vic_level_t;
endpackage : vic_pkg
`default_nettype wire

// ---- inc/vic_arb_if.sv ----
// Carrier between the request latch and the priority arbiter.
`timescale 1ns/1ns
`default_nettype none
interface vic_arb_if;
  logic [5:0] eligible;
  logic [7:0] priority_cfg;
  logic       win_valid;
  logic [2:0] win_level;
  modport ctl (output eligible, output priority_cfg, input win_valid, input win_level);
  modport arb (input eligible, input priority_cfg, output win_valid, output win_level);
endinterface : vic_arb_if
`default_nettype wire

// ---- logic/vic_priority_arbiter.sv ----
// Priority arbiter: orders six levels by the priority order register.
`timescale 1ns/1ns
`default_nettype none
`include "vic_cfg.svh"
module vic_priority_arbiter
  import vic_pkg::*;
(
  vic_arb_if.arb bus
);
  // -----------------------------------------------------------------
  // Pair and group ordering
  // -----------------------------------------------------------------
  wire logic [2:0] grp_code = {bus.priority_cfg[`VIC_PRI_ORD_2],
                               bus.priority_cfg[`VIC_PRI_ORD_1],
                               bus.priority_cfg[`VIC_PRI_ORD_0]};
  // Pair A is 5/3, pair B is 2/0, pair C is 1/4; first is higher while the pair's bit is clear.
  wire logic [2:0] a_hi = bus.priority_cfg[`VIC_PRI_GRP_A] ? 3'h3 : 3'h5;
  wire logic [2:0] a_lo = bus.priority_cfg[`VIC_PRI_GRP_A] ? 3'h5 : 3'h3;
  wire logic [2:0] b_hi = bus.priority_cfg[`VIC_PRI_GRP_B] ? 3'h0 : 3'h2;
  wire logic [2:0] b_lo = bus.priority_cfg[`VIC_PRI_GRP_B] ? 3'h2 : 3'h0;
  wire logic [2:0] c_hi = bus.priority_cfg[`VIC_PRI_GRP_C] ? 3'h4 : 3'h1;
  wire logic [2:0] c_lo = bus.priority_cfg[`VIC_PRI_GRP_C] ? 3'h1 : 3'h4;

  logic [17:0] order;
  // Unused codes 000, 001 and 111 fall back to C, A, B so no request stalls.
  always_comb begin
    unique case (grp_code)
      3'h2:    order = {a_hi, a_lo, b_hi, b_lo, c_hi, c_lo};
      3'h3:    order = {a_hi, a_lo, c_hi, c_lo, b_hi, b_lo};
      3'h4:    order = {b_hi, b_lo, c_hi, c_lo, a_hi, a_lo};
      3'h5:    order = {c_hi, c_lo, b_hi, b_lo, a_hi, a_lo};
      3'h6:    order = {b_hi, b_lo, a_hi, a_lo, c_hi, c_lo};
      default: order = {c_hi, c_lo, a_hi, a_lo, b_hi, b_lo};
    endcase
  end

  logic       found;
  logic [2:0] pick;
  always_comb begin
    found = 1'b0;
    pick  = 3'h0;
    for (int i = 5; i >= 0; i--) begin
      if (!found && bus.eligible[order[i*3 +: 3]]) begin
        found = 1'b1;
        pick  = order[i*3 +: 3];
      end
    end
  end
  assign bus.win_valid = found;
  assign bus.win_level = pick;
endmodule : vic_priority_arbiter
`default_nettype wire

// ---- logic/vic_interrupt_controller.sv ----
// Vectored interrupt controller: request latch, masks and acknowledge.
//
// Overview of operation
// - Mask bits 0..5 enable the matching request level.
// - Mask bit 7 is master enable; cleared, no level is recognised.
// - Enable instruction sets master enable; disable instruction clears it.
// - Master enable clears on entry to service; return sets it again.
// - Memory-protect mask bit is reserved and written as zero.
// - A request on a level sets its request register bit.
// - Request register is zero and read-only until the first enable instruction.
// - Writing mask bit 7 directly does not unlock the request register.
// - Request bits 6 and 7 read zero when reserved.
// - Request bits 7 and 6 pick trigger edges of two port pins.
// - Request bits written by software act as software requests.
// - Vector taken only with master, individual enable and highest priority.
// - Acknowledge pushes PC low, PC high, flags, then fetches vector high, low.
// - Acknowledge takes 24 clocks from recognition to first service fetch.
// - External requests pass two synchroniser flip-flops first.
// - Priority pairs 5/3, 2/0, 1/4; bits 1,2,5 within, 0,3,4 between.
// - Latched requests are sampled the last cycle before an opcode fetch.
// - An interrupt cycle clears only the winning level's request bit.
`timescale 1ns/1ns
`default_nettype none
`include "vic_cfg.svh"
module vic_interrupt_controller
  import vic_pkg::*;
#(
  parameter bit EDGE_SELECT_EN = 1'b1,
  parameter bit PROTECT_EN     = 1'b0
)
(
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic [5:0] int_source,
  input  wire logic       port3_pin1,
  input  wire logic       port3_pin2,
  input  wire logic       enable_interrupts_op,
  input  wire logic       disable_interrupts_op,
  input  wire logic       interrupt_return_op,
  input  wire logic       fetch_next,
  input  wire logic       mask_wr,
  input  wire logic       request_wr,
  input  wire logic       priority_wr,
  input  wire logic [7:0] wr_data,
  output logic [7:0]      mask_rd,
  output logic [7:0]      request_rd,
  output logic            ack_busy,
  output logic            push_pcl,
  output logic            push_pch,
  output logic            push_flags,
  output logic            fetch_vec_hi,
  output logic            fetch_vec_lo,
  output logic            branch_vec,
  output logic [7:0]      vector_addr,
  output logic            request_unlocked
);
  // -----------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------
  logic [7:0]     interrupt_mask_reg, interrupt_mask_next;
  logic [7:0]     interrupt_request_reg, interrupt_request_next;
  logic [7:0]     priority_order_register;
  logic           unlock_reg;
  logic [1:0]     p31_sync_reg, p32_sync_reg;
  logic           p31_prev_reg, p32_prev_reg;
  logic [5:0]     latch_reg, latch_next;
  logic [5:0]     src_prev_reg;
  logic [4:0]     ack_cnt_reg;
  vic_ack_state_t ack_state_reg, ack_state_next;
  vic_level_t     ack_level_reg;
  logic [7:0]     vector_addr_reg;
  logic [6:0]     step_reg;

  vic_arb_if arb_bus ();
  vic_priority_arbiter u_arb (.bus(arb_bus));

  function automatic logic [7:0] vec_addr(input logic [2:0] lvl);
    vec_addr = {4'h0, lvl, 1'b0};
  endfunction : vec_addr

  function automatic logic enters(input vic_ack_state_t nxt, input vic_ack_state_t cur,
                                  input vic_ack_state_t tgt);
    enters = (nxt == tgt) && (cur != tgt);
  endfunction : enters

  // -----------------------------------------------------------------
  // Edge detection on the two port pins
  // -----------------------------------------------------------------
  wire logic edge_hi = EDGE_SELECT_EN & interrupt_request_reg[`VIC_EDGE_HI_BIT];
  wire logic edge_lo = EDGE_SELECT_EN & interrupt_request_reg[`VIC_EDGE_LO_BIT];
  wire logic p31_rise = p31_sync_reg[1] & ~p31_prev_reg;
  wire logic p31_fall = ~p31_sync_reg[1] & p31_prev_reg;
  wire logic p32_rise = p32_sync_reg[1] & ~p32_prev_reg;
  wire logic p32_fall = ~p32_sync_reg[1] & p32_prev_reg;
  // 00 both fall, 01 pin1 fall pin2 rise, 10 pin1 rise pin2 fall, 11 both.
  wire logic p31_hit = (edge_hi ? p31_rise : p31_fall) | (edge_hi & edge_lo & p31_fall);
  wire logic p32_hit = (edge_lo ? p32_rise : p32_fall) | (edge_hi & edge_lo & p32_fall);
  // Pin 2 feeds level 0, pin 1 feeds level 2; internal sources are ORed in.
  wire logic [5:0] src_edge = int_source & ~src_prev_reg;
  wire logic [5:0] req_in   = src_edge | {3'h0, p31_hit, 1'b0, p32_hit};

  // -----------------------------------------------------------------
  // Request latch and sampling
  // -----------------------------------------------------------------
  wire logic sample    = fetch_next & (ack_state_reg == VIC_IDLE);
  wire logic master_en = interrupt_mask_reg[`VIC_MASTER_BIT];
  wire logic [5:0] eligible = interrupt_request_reg[5:0] & interrupt_mask_reg[5:0]
                              & {6{master_en}};
  assign arb_bus.eligible     = eligible;
  assign arb_bus.priority_cfg = priority_order_register;
  wire logic take = sample & arb_bus.win_valid;
  wire logic [5:0] win_onehot = 6'h01 << arb_bus.win_level;

  // Requests keep collecting between sample points; one that arrives in the
  // sample cycle itself waits in the latch for the next sample point.
  always_comb begin
    latch_next = (latch_reg | req_in) & {6{unlock_reg}};
    if (sample) begin
      latch_next = req_in & {6{unlock_reg}};
    end
  end

  always_comb begin
    interrupt_request_next = interrupt_request_reg;
    if (sample) begin
      interrupt_request_next[5:0] = interrupt_request_reg[5:0] | latch_reg;
    end
    if (take) begin
      interrupt_request_next[5:0] = interrupt_request_next[5:0] & ~win_onehot;
    end
    // Writes only land once unlocked; a software write creates requests.
    if (request_wr && unlock_reg) begin
      interrupt_request_next = wr_data;
      if (sample) begin
        interrupt_request_next[5:0] = wr_data[5:0] | latch_reg;
      end
    end
    if (!EDGE_SELECT_EN) begin
      interrupt_request_next[7:6] = 2'h0;
    end
    if (!unlock_reg) begin
      interrupt_request_next = `VIC_REQ_RESET;
    end
  end

  always_comb begin
    interrupt_mask_next = interrupt_mask_reg;
    if (mask_wr) begin
      interrupt_mask_next = wr_data;
    end
    if (!PROTECT_EN) begin
      interrupt_mask_next[`VIC_PROTECT_BIT] = 1'b0;
    end
    if (disable_interrupts_op) begin
      interrupt_mask_next[`VIC_MASTER_BIT] = 1'b0;
    end
    if (enable_interrupts_op || interrupt_return_op) begin
      interrupt_mask_next[`VIC_MASTER_BIT] = 1'b1;
    end
    if (take) begin
      interrupt_mask_next[`VIC_MASTER_BIT] = 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // Acknowledge sequencer
  // -----------------------------------------------------------------
  // At the n-th edge after the take the counter reads n. A state is left when
  // the counter reaches its constant, and each step pulses in the first cycle
  // of its state, so the pulses and the states cannot drift apart.
  wire logic [4:0] cnt = ack_cnt_reg;
  always_comb begin
    ack_state_next = ack_state_reg;
    unique case (ack_state_reg)
      VIC_IDLE:      if (take) ack_state_next = VIC_PUSH_PCL;
      VIC_PUSH_PCL:  if (cnt == `VIC_STEP_PCH) ack_state_next = VIC_PUSH_PCH;
      VIC_PUSH_PCH:  if (cnt == `VIC_STEP_FLG) ack_state_next = VIC_PUSH_FLG;
      VIC_PUSH_FLG:  if (cnt == `VIC_STEP_VHI) ack_state_next = VIC_FETCH_VHI;
      VIC_FETCH_VHI: if (cnt == `VIC_STEP_VLO) ack_state_next = VIC_FETCH_VLO;
      VIC_FETCH_VLO: if (cnt == `VIC_ACK_LAST) ack_state_next = VIC_BRANCH;
      VIC_BRANCH:    ack_state_next = VIC_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ack_cnt_reg <= 5'h00;
    end else if (take) begin
      ack_cnt_reg <= 5'h01;
    end else if (ack_state_reg != VIC_IDLE && ack_state_reg != VIC_BRANCH) begin
      ack_cnt_reg <= ack_cnt_reg + 5'h01;
    end else begin
      ack_cnt_reg <= 5'h00;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      step_reg <= 7'h00;
    end else begin
      step_reg <= {enters(ack_state_next, ack_state_reg, VIC_BRANCH),
                   enters(ack_state_next, ack_state_reg, VIC_FETCH_VLO),
                   enters(ack_state_next, ack_state_reg, VIC_FETCH_VHI),
                   enters(ack_state_next, ack_state_reg, VIC_PUSH_FLG),
                   enters(ack_state_next, ack_state_reg, VIC_PUSH_PCH),
                   take, 1'b0};
    end
  end
  assign push_pcl     = step_reg[1];
  assign push_pch     = step_reg[2];
  assign push_flags   = step_reg[3];
  assign fetch_vec_hi = step_reg[4];
  assign fetch_vec_lo = step_reg[5];
  assign branch_vec   = step_reg[6];

  // -----------------------------------------------------------------
  // State update
  // -----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      // Mask bits 0..6 are undefined after reset; zero is chosen here.
      interrupt_mask_reg      <= 8'h00;
      interrupt_request_reg   <= `VIC_REQ_RESET;
      priority_order_register <= 8'h00;
      unlock_reg              <= 1'b0;
      // Pin history resets high; an edge seen before the first enable meets
      // the locked latch and is lost.
      p31_sync_reg            <= 2'h3;
      p32_sync_reg            <= 2'h3;
      p31_prev_reg            <= 1'b1;
      p32_prev_reg            <= 1'b1;
      latch_reg               <= 6'h00;
      src_prev_reg            <= 6'h00;
      ack_state_reg           <= VIC_IDLE;
      ack_level_reg           <= 3'h0;
      vector_addr_reg         <= 8'h00;
    end else begin
      interrupt_mask_reg    <= interrupt_mask_next;
      interrupt_request_reg <= interrupt_request_next;
      if (priority_wr) begin
        priority_order_register <= wr_data;
      end
      if (enable_interrupts_op) begin
        unlock_reg <= 1'b1;
      end
      p31_sync_reg  <= {p31_sync_reg[0], port3_pin1};
      p32_sync_reg  <= {p32_sync_reg[0], port3_pin2};
      p31_prev_reg  <= p31_sync_reg[1];
      p32_prev_reg  <= p32_sync_reg[1];
      latch_reg     <= latch_next;
      src_prev_reg  <= int_source;
      ack_state_reg <= ack_state_next;
      if (take) begin
        ack_level_reg   <= arb_bus.win_level;
        vector_addr_reg <= vec_addr(arb_bus.win_level);
      end
    end
  end

  assign mask_rd          = interrupt_mask_reg;
  assign request_rd       = interrupt_request_reg;
  assign ack_busy         = ack_state_reg != VIC_IDLE;
  assign vector_addr      = vector_addr_reg;
  assign request_unlocked = unlock_reg;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_push;
    push_pcl ##4 push_pch ##4 push_flags;
  endsequence
  sequence s_fetch;
    fetch_vec_hi ##4 fetch_vec_lo;
  endsequence

  chk_ack_order: assert property (take |=> s_push ##6 s_fetch)
    else $error("acknowledge steps out of order");
  chk_ack_length: assert property (take |=> ##22 branch_vec)
    else $error("acknowledge not 24 cycles");
  chk_master_clear: assert property (take |=> !interrupt_mask_reg[7])
    else $error("master enable not cleared on entry");
  chk_ret_sets: assert property (interrupt_return_op && !take |=> interrupt_mask_reg[7])
    else $error("return did not set master enable");
  chk_no_master: assert property (!interrupt_mask_reg[7] |-> !take)
    else $error("interrupt taken with master off");
  chk_mask_gate: assert property (take |-> interrupt_mask_reg[arb_bus.win_level])
    else $error("masked level taken");
  chk_locked_zero: assert property (!unlock_reg |=> interrupt_request_reg == 8'h00)
    else $error("request register changed while locked");
  chk_win_clear: assert property (take && !request_wr
                                  |=> !interrupt_request_reg[ack_level_reg])
    else $error("winning request not cleared");
  chk_sync_delay: assert property ($rose(port3_pin1) |-> ##2 p31_sync_reg[1])
    else $error("synchroniser delay wrong");
  chk_sync_pin2: assert property ($rose(port3_pin2) |-> ##2 p32_sync_reg[1])
    else $error("pin 2 synchroniser delay wrong");
  chk_di_clear: assert property (disable_interrupts_op && !enable_interrupts_op
                                 && !interrupt_return_op |=> !interrupt_mask_reg[7])
    else $error("disable did not clear master");
  chk_ei_sets: assert property (enable_interrupts_op && !take
                                |=> interrupt_mask_reg[`VIC_MASTER_BIT])
    else $error("enable did not set master");

  // -----------------------------------------------------------------
  // Checks on arbitration, acknowledge steps, unlock, the request register and the vector
  // -----------------------------------------------------------------
  // Only an eligible level may win, so a masked or idle level never vectors.
  chk_win_eligible: assert property (take |-> eligible[arb_bus.win_level])
    else $error("winner was not an eligible level");
  chk_busy_no_take: assert property (ack_busy |-> !take)
    else $error("new take during acknowledge");
  chk_one_step: assert property ($onehot0(step_reg))
    else $error("two acknowledge steps at once");
  chk_vector_pair: assert property (take
                                    |=> vector_addr == {4'h0, ack_level_reg, 1'b0})
    else $error("vector address is not twice the level");

  // Only the enable instruction unlocks; a mask write with bit 7 set must not.
  chk_unlock_by_ei: assert property ($rose(unlock_reg)
                                     |-> $past(enable_interrupts_op))
    else $error("request register unlocked without enable");
  chk_mask_no_unlock: assert property (mask_wr && !enable_interrupts_op && !unlock_reg
                                       |=> !unlock_reg)
    else $error("mask write unlocked request register");
  chk_protect_zero: assert property (!PROTECT_EN
                                     |-> !interrupt_mask_reg[`VIC_PROTECT_BIT])
    else $error("reserved protect bit set");

  // Sampled requests land even beside a same-cycle write; only a take in the same cycle can clear one.
  chk_latch_lands: assert property (sample && unlock_reg && !request_wr && !take
                                    |=> (interrupt_request_reg[5:0] & $past(latch_reg))
                                        == $past(latch_reg))
    else $error("latched request not sampled");
  chk_sw_write: assert property (request_wr && unlock_reg && !sample
                                 |=> interrupt_request_reg[5:0] == $past(wr_data[5:0]))
    else $error("software request not stored");
endmodule : vic_interrupt_controller
`default_nettype wire

// ---- tb/vic_core_model.sv ----
// Behavioural processor core that marks the sample point before each opcode fetch.
`timescale 1ns/1ns
`default_nettype none
module vic_core_model #(
  parameter int FETCH_GAP = 4
)
(
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic run,
  input  wire logic slow,
  input  wire logic ack_busy,
  output logic      fetch_next
);
  logic fetch_reg = 1'b0;
  int   gap_cnt   = 0;
  assign fetch_next = fetch_reg;
  // ----------------------------------------------------------------
  // Fetch pacing
  // ----------------------------------------------------------------
  // A slow core runs long instructions, so sample points come far apart.
  // No fetch is marked while the acknowledge sequence owns the core.
  always @(negedge clock) begin
    if (!reset_n || !run || ack_busy) begin
      fetch_reg <= 1'b0;
      gap_cnt   <= 0;
    end else if (gap_cnt >= (slow ? 3 * FETCH_GAP : FETCH_GAP)) begin
      fetch_reg <= 1'b1;
      gap_cnt   <= 0;
    end else begin
      fetch_reg <= 1'b0;
      gap_cnt   <= gap_cnt + 1;
    end
  end
endmodule : vic_core_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking testbench for the vectored interrupt controller.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import vic_pkg::*;
  localparam logic [1:0] MSK = 2'h0, REQ = 2'h1, PRI = 2'h2;
  localparam logic [1:0] EI = 2'h0, DI = 2'h1, RET = 2'h2;
  localparam logic [7:0] STEP_AT [6] = '{8'h01, 8'h05, 8'h09, 8'h0F, 8'h13, 8'h17};
  localparam logic [7:0] PRI_CFG [6] = '{8'h01, 8'h03, 8'h08, 8'h28, 8'h10, 8'h14};
  localparam logic [2:0] PRI_WIN [6] = '{3'h1, 3'h4, 3'h5, 3'h3, 3'h2, 3'h0};
  localparam logic [3:0] EDGE_HIT [4] = '{4'hA, 4'h6, 4'h9, 4'hF};
  logic       clock = 1'b1, reset_n = 1'b0, core_run = 1'b0, core_slow = 1'b0;
  logic [5:0] int_source = 6'h00;
  logic       port3_pin1 = 1'b0, port3_pin2 = 1'b0;
  logic       enable_interrupts_op = 1'b0, disable_interrupts_op = 1'b0;
  logic       interrupt_return_op = 1'b0, fetch_next;
  logic       mask_wr = 1'b0, request_wr = 1'b0, priority_wr = 1'b0;
  logic [7:0] wr_data = 8'h00, mask_rd, request_rd, vector_addr;
  logic       ack_busy, push_pcl, push_pch, push_flags, fetch_vec_hi, fetch_vec_lo;
  logic       branch_vec, request_unlocked;
  int         miscompares = 0, checks = 0;

  always #10 clock = ~clock;

  vic_interrupt_controller dut (.clock(clock), .reset_n(reset_n), .int_source(int_source),
    .port3_pin1(port3_pin1), .port3_pin2(port3_pin2),
    .enable_interrupts_op(enable_interrupts_op), .disable_interrupts_op(disable_interrupts_op),
    .interrupt_return_op(interrupt_return_op), .fetch_next(fetch_next), .mask_wr(mask_wr),
    .request_wr(request_wr), .priority_wr(priority_wr), .wr_data(wr_data), .mask_rd(mask_rd),
    .request_rd(request_rd), .ack_busy(ack_busy), .push_pcl(push_pcl), .push_pch(push_pch),
    .push_flags(push_flags), .fetch_vec_hi(fetch_vec_hi), .fetch_vec_lo(fetch_vec_lo),
    .branch_vec(branch_vec), .vector_addr(vector_addr), .request_unlocked(request_unlocked));
  vic_core_model core (.clock(clock), .reset_n(reset_n), .run(core_run), .slow(core_slow),
    .ack_busy(ack_busy), .fetch_next(fetch_next));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    if (miscompares == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick
  // Strobes drop a full cycle before the next task may raise them again.
  task automatic wr(input logic [1:0] sel, input logic [7:0] d);
    mask_wr = (sel == MSK);
    request_wr = (sel == REQ);
    priority_wr = (sel == PRI);
    wr_data = d;
    tick(1);
    {mask_wr, request_wr, priority_wr} = 3'h0;
    tick(1);
  endtask : wr
  task automatic op(input logic [1:0] which);
    enable_interrupts_op = (which == EI);
    disable_interrupts_op = (which == DI);
    interrupt_return_op = (which == RET);
    tick(1);
    {enable_interrupts_op, disable_interrupts_op, interrupt_return_op} = 3'h0;
    tick(1);
  endtask : op
  task automatic wait_busy;
    int n;
    n = 0;
    while (ack_busy !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    check("ack start", {7'h00, ack_busy}, 8'h01);
  endtask : wait_busy
  task automatic no_take(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      if (ack_busy !== 1'b0) seen = 1'b1;
      tick(1);
    end
    check("no take", {7'h00, seen}, 8'h00);
  endtask : no_take
  // Entered on the first busy cycle; records where each step pulse lands.
  task automatic watch_steps;
    logic [7:0] at [6];
    logic [7:0] busy_n;
    logic [5:0] p;
    at = '{6{8'h00}};
    busy_n = 8'h00;
    for (int c = 1; c < 30; c++) begin
      p = {branch_vec, fetch_vec_lo, fetch_vec_hi, push_flags, push_pch, push_pcl};
      for (int k = 0; k < 6; k++) if (p[k] === 1'b1 && at[k] == 8'h00) at[k] = 8'(c);
      if (ack_busy === 1'b1) busy_n++;
      tick(1);
    end
    for (int k = 0; k < 6; k++) check("step cycle", at[k], STEP_AT[k]);
    check("busy cycles", busy_n, 8'h17);
  endtask : watch_steps

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    check("mask reset", mask_rd, 8'h00);
    check("request reset", request_rd, 8'h00);
    check("unlocked reset", {7'h00, request_unlocked}, 8'h00);
    wr(REQ, 8'h15);
    check("locked write", request_rd, 8'h00);
    wr(MSK, 8'h80);
    wr(REQ, 8'h01);
    check("master write", {7'h00, request_unlocked}, 8'h00);
    check("still locked", request_rd, 8'h00);
  endtask : t_reset
  task automatic t_init;
    wr(MSK, 8'h00);
    op(EI);
    check("ei master", mask_rd, 8'h80);
    check("unlocked", {7'h00, request_unlocked}, 8'h01);
    op(DI);
    check("di master", mask_rd, 8'h00);
    wr(REQ, 8'hC5);
    check("request rw", request_rd, 8'hC5);
    wr(MSK, 8'h7F);
    check("protect bit", mask_rd, 8'h3F);
    no_take(40);
    check("pending", request_rd, 8'hC5);
    wr(REQ, 8'h00);
  endtask : t_init
  // All six levels pend at once, so each order picks a different winner.
  task automatic t_prio;
    for (int k = 0; k < 6; k++) begin
      op(DI);
      wr(PRI, PRI_CFG[k]);
      wr(REQ, 8'h3F);
      wr(MSK, 8'h3F);
      op(EI);
      wait_busy();
      check("vector", vector_addr, {4'h0, PRI_WIN[k], 1'b0});
      check("master auto off", mask_rd, 8'h3F);
      check("winner cleared", request_rd, 8'h3F & ~(8'h01 << PRI_WIN[k]));
      watch_steps();
      wr(MSK, 8'h00);
      op(RET);
      check("master on return", mask_rd, 8'h80);
    end
  endtask : t_prio
  task automatic t_mask;
    op(DI);
    wr(REQ, 8'h01);
    wr(MSK, 8'h3E);
    op(EI);
    no_take(40);
    op(DI);
    wr(MSK, 8'h01);
    op(EI);
    wait_busy();
    check("lone vector", vector_addr, 8'h00);
    check("lone cleared", request_rd, 8'h00);
    tick(30);
    wr(MSK, 8'h00);
  endtask : t_mask
  // Polled use: masks stay clear and flags are cleared by writes.
  task automatic t_edges;
    core_slow = 1'b1;
    for (int c = 0; c < 4; c++) begin
      for (int p = 0; p < 4; p++) begin
        wr(REQ, {2'(c), 6'h00});
        if (p < 2) port3_pin1 = (p == 0);
        else port3_pin2 = (p == 2);
        tick(45);
        check("edge flag", request_rd, {2'(c), 3'h0, EDGE_HIT[c][p] && p < 2, 1'b0,
          EDGE_HIT[c][p] && p >= 2});
      end
    end
    for (int i = 0; i < 6; i++) begin
      wr(REQ, 8'h00);
      int_source[i] = 1'b1;
      tick(45);
      check("source flag", request_rd, 8'(1 << i));
      int_source[i] = 1'b0;
    end
  endtask : t_edges
  // A reset in mid-run must clear the masks and lock the request register again.
  task automatic t_rerun;
    reset_n = 1'b0;
    tick(2);
    reset_n = 1'b1;
    check("rerun mask", mask_rd, 8'h00);
    check("rerun request", request_rd, 8'h00);
    check("rerun locked", {7'h00, request_unlocked}, 8'h00);
    wr(REQ, 8'h01);
    check("rerun write", request_rd, 8'h00);
  endtask : t_rerun

  initial begin
    repeat (5) @(negedge clock);
    reset_n = 1'b1;
    core_run = 1'b1;
    t_reset();
    t_init();
    t_prio();
    t_mask();
    t_edges();
    t_rerun();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
